// [rtl/atrb_bank.v]
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
`include "atrb_consts.vh"

// How it works
// - Core A, first input, single mode, calibration on: use single-mode register bits 11:0.
// - Core A, second input, 90-degree phase, calibration on: use register at 0x34A.
// - Core B, first input, calibration on: use register 0x34C in either mode.
// - Core B, second input, calibration on: use register 0x34E in either mode.
// - Dual mode: bank 0 of core A gets fine gain bits 4:0 of 0x350.
// - Dual mode: bank 1 of core A gets fine gain bits 4:0 of 0x351.
// - Trims load from fuse storage; software may overwrite them afterwards.
// - Core A, first input, dual mode, calibration on: use register at 0x344.
module atrb_bank (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire [13:0] avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    input  wire [15:0] fuse_ofs_a_dual_in1_i,
    input  wire [15:0] fuse_ofs_a_single_in1_i,
    input  wire [15:0] fuse_ofs_a_ph90_in2_i,
    input  wire [15:0] fuse_ofs_b_in1_i,
    input  wire [15:0] fuse_ofs_b_in2_i,
    input  wire [7:0]  fuse_gain_bank0_i,
    input  wire [7:0]  fuse_gain_bank1_i,
    output reg  [11:0] core_a_offset_o,
    output reg  [11:0] core_b_offset_o,
    output reg         core_a_offset_valid_o,
    output reg         core_b_offset_valid_o,
    output reg  [4:0]  core_a_bank0_gain_o,
    output reg  [4:0]  core_a_bank1_gain_o,
    output reg         gain_valid_o
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [15:0] ofs_reg [0:4];
    reg [7:0]  gain_reg [0:1];
    reg [3:0]  ctrl;
    reg        loaded;
    reg        load_req;
    reg        ack_pend;
    wire [15:0] fuse_ofs [0:4];
    wire [7:0]  fuse_gain [0:1];

    assign fuse_ofs[0] = fuse_ofs_a_dual_in1_i;
    assign fuse_ofs[1] = fuse_ofs_a_single_in1_i;
    assign fuse_ofs[2] = fuse_ofs_a_ph90_in2_i;
    assign fuse_ofs[3] = fuse_ofs_b_in1_i;
    assign fuse_ofs[4] = fuse_ofs_b_in2_i;
    assign fuse_gain[0] = fuse_gain_bank0_i;
    assign fuse_gain[1] = fuse_gain_bank1_i;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Offset register slot 0..4, or 7 when not an offset register
    function [2:0] ofs_slot;
        input [13:0] a;
        begin
            case (a[13:2])
                `ATRB_IDX_A_DUAL_IN1:   ofs_slot = 3'd0;
                `ATRB_IDX_A_SINGLE_IN1: ofs_slot = 3'd1;
                `ATRB_IDX_A_PH90_IN2:   ofs_slot = 3'd2;
                `ATRB_IDX_B_IN1:        ofs_slot = 3'd3;
                `ATRB_IDX_B_IN2:        ofs_slot = 3'd4;
                default:                ofs_slot = 3'd7;
            endcase
        end
    endfunction

    // Gain register slot 0..1, or 3 when not a gain register
    function [1:0] gain_slot;
        input [13:0] a;
        begin
            case (a[13:2])
                `ATRB_IDX_A_GAIN_BANK0: gain_slot = 2'd0;
                `ATRB_IDX_A_GAIN_BANK1: gain_slot = 2'd1;
                default:                gain_slot = 2'd3;
            endcase
        end
    endfunction

    wire [2:0] wr_ofs   = ofs_slot(avs_address_i);
    wire [1:0] wr_gain  = gain_slot(avs_address_i);
    wire       bus_req  = (avs_read_i | avs_write_i) & ~ack_pend;
    wire       wr_go    = avs_write_i & ack_pend;
    wire       is_ctrl  = (avs_address_i[13:2] == `ATRB_IDX_CTRL);
    wire       is_stat  = (avs_address_i[13:2] == `ATRB_IDX_STATUS);
    wire       reload   = wr_go & is_ctrl & avs_byteenable_i[0]
                          & avs_writedata_i[`ATRB_CTRL_RELOAD_BIT];

    // ----------------------------------------
    // Fuse load and register writes
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_ofs
            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    ofs_reg[gi] <= `ATRB_RST_OFS;
                end else if (load_req) begin
                    ofs_reg[gi] <= fuse_ofs[gi];
                end else if (wr_go && wr_ofs == gi) begin
                    if (avs_byteenable_i[0]) begin
                        ofs_reg[gi][7:0] <= avs_writedata_i[7:0];
                    end
                    if (avs_byteenable_i[1]) begin
                        ofs_reg[gi][15:8] <= avs_writedata_i[15:8];
                    end
                end
            end
        end
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_gain
            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    gain_reg[gi] <= `ATRB_RST_GAIN;
                end else if (load_req) begin
                    gain_reg[gi] <= fuse_gain[gi];
                end else if (wr_go && wr_gain == gi && avs_byteenable_i[0]) begin
                    gain_reg[gi] <= avs_writedata_i[7:0];
                end
            end
        end
    endgenerate

    // Fuse load one cycle after reset release, or on software reload
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            load_req <= 1'b1;
            loaded   <= 1'b0;
            ctrl     <= `ATRB_RST_CTRL;
        end else begin
            load_req <= reload;
            if (load_req) begin
                loaded <= 1'b1;
            end
            if (wr_go && is_ctrl && avs_byteenable_i[0]) begin
                ctrl <= avs_writedata_i[3:0];
            end
        end
    end

    // ----------------------------------------
    // Avalon-MM slave: one wait cycle per access
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_pend          <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
        end else begin
            ack_pend          <= bus_req;
            avs_waitrequest_o <= ~bus_req;
            if (bus_req && avs_read_i) begin
                if (wr_ofs != 3'd7) begin
                    avs_readdata_o <= {16'h0000, ofs_reg[wr_ofs]};
                end else if (wr_gain != 2'd3) begin
                    avs_readdata_o <= {24'h000000, gain_reg[wr_gain[0]]};
                end else if (is_ctrl) begin
                    avs_readdata_o <= {28'h0000000, ctrl};
                end else if (is_stat) begin
                    avs_readdata_o <= {26'h0000000, core_b_offset_valid_o,
                                       core_a_offset_valid_o, ctrl};
                end else begin
                    avs_readdata_o <= 32'h00000000;
                end
            end
        end
    end

    // ----------------------------------------
    // Correction selection
    // ----------------------------------------
    wire core_b = ctrl[`ATRB_CTRL_CORE_B_BIT];
    wire in2    = ctrl[`ATRB_CTRL_IN2_BIT];
    wire single = ctrl[`ATRB_CTRL_SINGLE_BIT];
    wire fgcal  = ctrl[`ATRB_CTRL_FGCAL_BIT];

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            core_a_offset_o       <= 12'h000;
            core_b_offset_o       <= 12'h000;
            core_a_offset_valid_o <= 1'b0;
            core_b_offset_valid_o <= 1'b0;
            core_a_bank0_gain_o   <= 5'h00;
            core_a_bank1_gain_o   <= 5'h00;
            gain_valid_o          <= 1'b0;
        end else begin
            core_a_offset_valid_o <= 1'b0;
            core_b_offset_valid_o <= 1'b0;
            core_a_offset_o       <= 12'h000;
            core_b_offset_o       <= 12'h000;
            if (loaded && fgcal && !core_b) begin
                core_a_offset_valid_o <= 1'b1;
                if (!in2 && !single) begin
                    core_a_offset_o <= ofs_reg[0][`ATRB_OFS_MSB:0];
                end else if (!in2) begin
                    core_a_offset_o <= ofs_reg[1][`ATRB_OFS_MSB:0];
                end else if (single) begin
                    core_a_offset_o <= ofs_reg[2][`ATRB_OFS_MSB:0];
                end else begin
                    core_a_offset_valid_o <= 1'b0;
                end
            end
            if (loaded && fgcal && core_b) begin
                core_b_offset_valid_o <= 1'b1;
                if (!in2) begin
                    core_b_offset_o <= ofs_reg[3][`ATRB_OFS_MSB:0];
                end else begin
                    core_b_offset_o <= ofs_reg[4][`ATRB_OFS_MSB:0];
                end
            end
            gain_valid_o        <= loaded & ~single;
            core_a_bank0_gain_o <= single ? 5'h00 : gain_reg[0][`ATRB_GAIN_MSB:0];
            core_a_bank1_gain_o <= single ? 5'h00 : gain_reg[1][`ATRB_GAIN_MSB:0];
        end
    end

endmodule // atrb_bank

// [rtl/atrb_consts.vh]
`ifndef ATRB_CONSTS_VH
`define ATRB_CONSTS_VH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define ATRB_IDX_A_DUAL_IN1     12'h344
`define ATRB_IDX_A_SINGLE_IN1   12'h348
`define ATRB_IDX_A_PH90_IN2     12'h34a
`define ATRB_IDX_B_IN1          12'h34c
`define ATRB_IDX_B_IN2          12'h34e
`define ATRB_IDX_A_GAIN_BANK0   12'h350
`define ATRB_IDX_A_GAIN_BANK1   12'h351
`define ATRB_IDX_CTRL           12'h360
`define ATRB_IDX_STATUS         12'h361

// ----------------------------------------
// Field layout
// ----------------------------------------
`define ATRB_OFS_MSB            11
`define ATRB_GAIN_MSB           4
`define ATRB_OFS_REG_W          16
`define ATRB_GAIN_REG_W         8
`define ATRB_CTRL_CORE_B_BIT    0
`define ATRB_CTRL_IN2_BIT       1
`define ATRB_CTRL_SINGLE_BIT    2
`define ATRB_CTRL_FGCAL_BIT     3
`define ATRB_CTRL_RELOAD_BIT    4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ATRB_RST_OFS            16'h0000
`define ATRB_RST_GAIN           8'h00
`define ATRB_RST_CTRL           4'h0

`endif

// [tb/atrb_bank_chk.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Port checker
// ----------------------------------------
module atrb_chk (
    input logic        clk_i,
    input logic        rst_n_i,
    input logic [13:0] avs_address_i,
    input logic        avs_read_i,
    input logic        avs_write_i,
    input logic [31:0] avs_writedata_i,
    input logic [3:0]  avs_byteenable_i,
    input logic        avs_waitrequest_o,
    input logic [11:0] core_a_offset_o,
    input logic [11:0] core_b_offset_o,
    input logic        core_a_offset_valid_o,
    input logic        core_b_offset_valid_o,
    input logic [4:0]  core_a_bank0_gain_o,
    input logic [4:0]  core_a_bank1_gain_o,
    input logic        gain_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire wack = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    a_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_wait_ans: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("request not answered");
    a_ans_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
        else $error("answer without request");
    a_gain0_wr: assert property (wack && avs_address_i == 14'hd40 && gain_valid_o
        |-> ##2 core_a_bank0_gain_o == $past(avs_writedata_i[4:0], 2)) else $error("bank0 gain");
    a_gain1_wr: assert property (wack && avs_address_i == 14'hd44 && gain_valid_o
        |-> ##2 core_a_bank1_gain_o == $past(avs_writedata_i[4:0], 2)) else $error("bank1 gain");
    a_gain_off: assert property (!gain_valid_o |-> {core_a_bank0_gain_o, core_a_bank1_gain_o}
        == 10'h0) else $error("gain not zero");
    a_a_zero: assert property (!core_a_offset_valid_o |-> core_a_offset_o == 12'h0)
        else $error("core a offset not zero");
    a_b_zero: assert property (!core_b_offset_valid_o |-> core_b_offset_o == 12'h0)
        else $error("core b offset not zero");
    a_one_core: assert property (!(core_a_offset_valid_o && core_b_offset_valid_o))
        else $error("both cores valid");
    cover property (core_a_offset_valid_o);
    cover property (core_b_offset_valid_o);
    cover property (wack && gain_valid_o);
endmodule // atrb_chk

// [tb/atrb_bank_tb.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Bench top
// ----------------------------------------
module testbench;
    logic        clk_i = 0;
    logic        rst_n_i = 0;
    logic        rd = 0, wr = 0, wq, av, bv, gv;
    logic [13:0] adr = 0;
    logic [3:0]  be = 0;
    logic [31:0] wd = 0, rdat, q, t, u;
    logic [11:0] ao, bo;
    logic [4:0]  g0, g1;
    logic [10:0] eg;
    logic [15:0] fo [5] = '{16'h1abc, 16'h2bcd, 16'h3cde, 16'h4def, 16'h5f01};
    logic [7:0]  fg [2] = '{8'he5, 8'h3a};
    logic [13:0] ra [7] = '{14'hd10, 14'hd20, 14'hd28, 14'hd30, 14'hd38, 14'hd40, 14'hd44};
    int          n_mismatch = 0, n_compared = 0, k;
    always #5 clk_i = ~clk_i;
    atrb_bank dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .fuse_ofs_a_dual_in1_i(fo[0]), .fuse_ofs_a_single_in1_i(fo[1]),
        .fuse_ofs_a_ph90_in2_i(fo[2]), .fuse_ofs_b_in1_i(fo[3]), .fuse_ofs_b_in2_i(fo[4]),
        .fuse_gain_bank0_i(fg[0]), .fuse_gain_bank1_i(fg[1]), .core_a_offset_o(ao),
        .core_b_offset_o(bo), .core_a_offset_valid_o(av), .core_b_offset_valid_o(bv),
        .core_a_bank0_gain_o(g0), .core_a_bank1_gain_o(g1), .gain_valid_o(gv));
    function automatic logic [31:0] nv(input int i);
        return {20'hfffff, 12'(12'h1a1 * (i + 1))};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d,
                       input logic [3:0] e);
        @(posedge clk_i);
        adr <= a;
        wd <= d;
        be <= e;
        wr <= w;
        rd <= !w;
        do @(posedge clk_i); while (wq !== 1'b0);
        q = rdat;
        wr <= 0;
        rd <= 0;
        @(posedge clk_i);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 7; i++) begin
            bus(0, ra[i], 0, 4'hf);
            chk(q, i < 5 ? fo[i] : fg[i - 5]);
        end
        $display("fuse defaults done");
        for (int i = 0; i < 7; i++) bus(1, ra[i], nv(i), 4'hf);
        for (int i = 0; i < 7; i++) begin
            t = nv(i);
            bus(0, ra[i], 0, 4'hf);
            chk(q, i < 5 ? t[15:0] : t[7:0]);
        end
        bus(1, 14'hd4c, 32'h1234, 4'hf);
        bus(0, 14'hd4c, 0, 4'hf);
        chk(q, 0);
        $display("overwrite done");
        u = nv(5);
        eg = {1'b1, u[4:0], 5'h0};
        u = nv(6);
        eg[4:0] = u[4:0];
        for (int c = 0; c < 16; c++) begin
            bus(1, 14'hd80, c, 4'hf);
            @(negedge clk_i);
            k = !c[3] ? 9 : c[0] ? 3 + c[1] : !c[1] ? c[2] : c[2] ? 2 : 9;
            t = k < 9 ? nv(k) : 0;
            chk({av, ao}, k < 3 ? {1'b1, t[11:0]} : 13'h0);
            chk({bv, bo}, (k == 3 || k == 4) ? {1'b1, t[11:0]} : 13'h0);
            chk({gv, g0, g1}, c[2] ? 11'h0 : eg);
        end
        $display("selection done");
        bus(1, 14'hd80, 32'h8, 4'hf);
        bus(1, 14'hd10, 32'h5555, 4'h1);
        t = nv(0);
        bus(0, 14'hd10, 0, 4'hf);
        chk(q, {t[15:8], 8'h55});
        chk(ao, {t[11:8], 8'h55});
        bus(1, 14'hd80, 32'h18, 4'hf);
        bus(0, 14'hd10, 0, 4'hf);
        chk(q, fo[0]);
        chk(ao, fo[0][11:0]);
        $display("lane and reload done");
        end_of_test;
    end
endmodule // testbench
bind atrb_bank atrb_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
    .core_a_offset_o(core_a_offset_o), .core_b_offset_o(core_b_offset_o),
    .core_a_offset_valid_o(core_a_offset_valid_o), .core_b_offset_valid_o(core_b_offset_valid_o),
    .core_a_bank0_gain_o(core_a_bank0_gain_o), .core_a_bank1_gain_o(core_a_bank1_gain_o),
    .gain_valid_o(gain_valid_o));
